// [rtl/pic_consts.vh]
// Constants of the priority interrupt controller: register offsets, field positions,
// reset values and timing counts. Included by pic_tick, pic_top, the checker and the testbench.
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH

// Register byte offsets on the AHB-Lite slave.
`define PIC_OFS_STATUS 8'h00
`define PIC_OFS_CONFIG 8'h04
`define PIC_OFS_INSERV 8'h08
`define PIC_OFS_ACK 8'h0c
`define PIC_OFS_VECTOR 8'h10
`define PIC_OFS_CMD 8'h14
`define PIC_OFS_CMDDATA 8'h18
// Configuration word fields: [7:3] vector base, [2] rotate mode, [1:0] reserved.
`define PIC_CFG_BASE_LSB 3
`define PIC_CFG_ROTATE_BIT 2
// Command port field: [0] is the single address bit.
`define PIC_CMD_A0_BIT 0
// Command port control fields: [8] select, [9] read strobe, [10] write strobe.
`define PIC_CMD_CS_BIT 8
`define PIC_CMD_RD_BIT 9
`define PIC_CMD_WR_BIT 10
// Reset values.
`define PIC_RST_CONFIG 8'h00
`define PIC_RST_MASK 8'hff
// Tick period in nanoseconds and clock period in nanoseconds.
`define PIC_TICK_NS 13107200
`define PIC_CLK_NS 40
`define PIC_TICK_CYC (`PIC_TICK_NS / `PIC_CLK_NS)
// Fixed line of each source.
`define PIC_LINE_TICK 4
`define PIC_LINE_AUX 3

`endif

// [rtl/pic_sync.v]
// Two-flop synchroniser bank for the eight asynchronous request inputs.
// Assumes the inputs come from pins outside the clock domain.
`timescale 1ns/1ps
module pic_sync (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_n_i,
    // Raw and synchronised request lines.
    input wire [7:0] raw_i,
    output wire [7:0] sync_o
);
    // First stage is read only by the second stage.
    reg [7:0] meta_q;
    // Second stage feeds the logic.
    reg [7:0] sync_q;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_bit
            // Each bit passes two flops.
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= raw_i[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;
endmodule

// [rtl/pic_tick.v]
// Free-running periodic tick generator for the real-time request source.
// Assumes a single system clock; period is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`include "pic_consts.vh"
module pic_tick #(
    parameter [31:0] TICK_CYC = `PIC_TICK_CYC
) (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_n_i,
    // One-cycle pulse each period.
    output wire tick_o
);
    // Down counter of cycles to the next tick.
    reg [31:0] cnt_q;
    // Registered pulse.
    reg tick_q;

    // Counter runs without stopping and reloads on expiry.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'h0) begin
            cnt_q <= TICK_CYC - 32'h1;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 32'h1;
            tick_q <= 1'b0;
        end
    end

    assign tick_o = tick_q;
endmodule

// [rtl/pic_top.v]
// Priority interrupt controller: eight request lines, mask, priority, two-pulse
// acknowledge returning a vector pointer, and an 8-bit command port with one address bit.
// Assumes an AHB-Lite master on clk_sys_i and request pins asynchronous to it.
// Behaviour
// - Eight request inputs, own bit and vector.
// - Tick source requests every 13.1072 ms.
// - Keyline-open request only on rising edge.
// - Auxiliary receive input may stay unused.
// - Dedicated interrupt output line to processor.
// - Read access returns the request lines; tick bit 4 reads zero.
// - Each source gets a distinct type number.
// - Masked sources never interrupt the processor.
// - Written word sets mode, type, mask.
// - Requests presented in programmed priority order.
// - Address bit with strobes selects word.
// - High request sets its pending bit; keyline-closed line 6 is also set only on its rising edge.
// - Interrupt only when a request qualifies.
// - First pulse: set in-service, clear pending.
// - First pulse leaves data bus undriven.
// - Second pulse drives 8-bit vector pointer.
// - In-service bit clears when second pulse ends.
`timescale 1ns/1ps
`include "pic_consts.vh"
module pic_top #(
    parameter [31:0] TICK_CYC = `PIC_TICK_CYC
) (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_n_i,
    // AHB-Lite slave.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // Request pins; line 4 is the internal tick, its pin slot is ignored.
    input wire rf_module_attention_req_i,
    input wire remote_receive_ready_req_i,
    input wire remote_transmit_ready_req_i,
    input wire remote_receive_ready_aux_req_i,
    input wire front_panel_attention_req_i,
    input wire keyline_closed_req_i,
    input wire keyline_open_req_i,
    // Processor interrupt line.
    output wire int_req_o,
    // Acknowledge handshake pins; data pins are two signals, value and enable.
    input wire int_ack_i,
    output wire [7:0] data_o,
    output wire data_oe_o
);
    // Synchronised request lines.
    wire [7:0] req_sync;
    // Tick pulse.
    wire tick;
    // Previous sampled level of the edge-triggered keyline lines.
    reg [1:0] key_prev_q;
    // Pending request bits.
    reg [7:0] pending_request_bits_q;
    // In-service bits.
    reg [7:0] in_service_bits_q;
    // Mask, configuration and configured flag.
    reg [7:0] mask_q;
    reg [7:0] cfg_q;
    reg configured_q;
    // Rotating priority start line.
    reg [2:0] prio_base_q;
    // Acknowledge sequencing.
    reg [1:0] ack_st_q;
    reg ack_prev_q;
    reg [2:0] sel_line_q;
    // Outputs from flops.
    reg int_q;
    reg [7:0] data_q;
    reg data_oe_q;
    // Command port byte held for reads.
    reg [7:0] cmd_rdata_q;
    // Bus registers.
    reg [31:0] hrdata_q;
    reg ph_wr_q;
    reg ph_rd_q;
    reg [7:0] ph_addr_q;

    // Acknowledge states.
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_FIRST = 2'b01;
    localparam [1:0] ST_WAIT2 = 2'b10;
    localparam [1:0] ST_SECOND = 2'b11;

    // Pins pass two flops before any logic reads them.
    pic_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .raw_i({keyline_open_req_i, keyline_closed_req_i, front_panel_attention_req_i, 1'b0,
                remote_receive_ready_aux_req_i, remote_transmit_ready_req_i,
                remote_receive_ready_req_i, rf_module_attention_req_i}),
        .sync_o(req_sync)
    );

    // Free-running tick source.
    pic_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick)
    );

    // Raw event vector: levels for most lines, edges for the keylines, pulse for the tick.
    wire [7:0] raw_evt;
    assign raw_evt[3:0] = req_sync[3:0];
    assign raw_evt[`PIC_LINE_TICK] = tick;
    assign raw_evt[5] = req_sync[5];
    assign raw_evt[7:6] = req_sync[7:6] & ~key_prev_q;

    // Unmasked pending candidates.
    wire [7:0] cand = pending_request_bits_q & ~mask_q;

    // Priority search starting at the rotating base; lowest index wins in fixed mode.
    reg [2:0] win_line;
    reg win_found;
    reg [2:0] idx;
    integer k;
    always @* begin
        win_line = 3'h0;
        win_found = 1'b0;
        idx = 3'h0;
        for (k = 7; k >= 0; k = k - 1) begin
            // Fixed mode ignores any base left over from an earlier rotating run.
            idx = (cfg_q[`PIC_CFG_ROTATE_BIT] ? prio_base_q : 3'h0) + k[2:0];
            if (cand[idx]) begin
                win_line = idx;
                win_found = 1'b1;
            end
        end
    end

    // Command port decode from the single address bit and strobes.
    wire cmd_hit = ph_wr_q && (ph_addr_q == `PIC_OFS_CMD);
    wire cmd_cs = hwdata[`PIC_CMD_CS_BIT];
    wire cmd_rd = cmd_hit && cmd_cs && hwdata[`PIC_CMD_RD_BIT];
    wire cmd_wr = cmd_hit && cmd_cs && hwdata[`PIC_CMD_WR_BIT];
    wire cmd_a0 = hwdata[`PIC_CMD_A0_BIT];

    // Acknowledge pulses arrive on a pin and are synchronised here.
    reg ack_m_q;
    reg ack_s_q;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
        end else begin
            ack_m_q <= int_ack_i;
            ack_s_q <= ack_m_q;
        end
    end
    wire ack_rise = ack_s_q && !ack_prev_q;
    wire ack_fall = !ack_s_q && ack_prev_q;

    // Software acknowledge pulse register, an alternative to the pin.
    wire sw_ack = ph_wr_q && (ph_addr_q == `PIC_OFS_ACK);

    // Pending, in-service and acknowledge sequence.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_prev_q <= 2'b00;
            pending_request_bits_q <= 8'h00;
            in_service_bits_q <= 8'h00;
            ack_prev_q <= 1'b0;
            ack_st_q <= ST_IDLE;
            sel_line_q <= 3'h0;
            prio_base_q <= 3'h0;
            data_q <= 8'h00;
            data_oe_q <= 1'b0;
        end else begin
            key_prev_q <= req_sync[7:6];
            ack_prev_q <= ack_s_q;
            case (ack_st_q)
                ST_IDLE: begin
                    data_oe_q <= 1'b0;
                    // First pulse with a winner moves it into service.
                    if ((ack_rise || sw_ack) && win_found && configured_q) begin
                        sel_line_q <= win_line;
                        in_service_bits_q[win_line] <= 1'b1;
                        ack_st_q <= sw_ack ? ST_WAIT2 : ST_FIRST;
                    end
                end
                ST_FIRST: begin
                    data_oe_q <= 1'b0;
                    if (ack_fall) begin
                        ack_st_q <= ST_WAIT2;
                    end
                end
                ST_WAIT2: begin
                    // Second pulse drives the pointer.
                    if (ack_rise || sw_ack) begin
                        data_q <= {cfg_q[7:`PIC_CFG_BASE_LSB], sel_line_q};
                        data_oe_q <= ack_rise;
                        ack_st_q <= sw_ack ? ST_IDLE : ST_SECOND;
                        if (sw_ack) begin
                            in_service_bits_q[sel_line_q] <= 1'b0;
                        end
                    end
                end
                ST_SECOND: begin
                    // Pulse end completes the cycle.
                    if (ack_fall) begin
                        data_oe_q <= 1'b0;
                        in_service_bits_q[sel_line_q] <= 1'b0;
                        ack_st_q <= ST_IDLE;
                        if (cfg_q[`PIC_CFG_ROTATE_BIT]) begin
                            prio_base_q <= sel_line_q + 3'h1;
                        end
                    end
                end
                default: begin
                    ack_st_q <= ST_IDLE;
                end
            endcase
            // Sources set pending; a set in the clearing cycle wins.
            pending_request_bits_q <= (pending_request_bits_q
                & ~((ack_st_q == ST_IDLE && (ack_rise || sw_ack) && win_found && configured_q)
                    ? (8'h01 << win_line) : 8'h00)) | raw_evt;
        end
    end

    // Interrupt line: asserted while a candidate waits and no cycle is in progress.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_q <= 1'b0;
        end else begin
            int_q <= configured_q && win_found && (ack_st_q == ST_IDLE)
                && !(ack_rise || sw_ack);
        end
    end

    // Command port and configuration.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_q <= `PIC_RST_MASK;
            cfg_q <= `PIC_RST_CONFIG;
            configured_q <= 1'b0;
            cmd_rdata_q <= 8'h00;
        end else if (cmd_wr) begin
            // A0 low: mode/type word; A0 high: mask word.
            if (cmd_a0) begin
                mask_q <= hwdata[23:16];
            end else begin
                cfg_q <= hwdata[23:16];
                configured_q <= 1'b1;
            end
        end else if (cmd_rd) begin
            cmd_rdata_q <= cmd_a0 ? mask_q : req_sync;
        end
    end

    // AHB-Lite address phase capture.
    wire ph_take = hsel && hready && htrans[1];
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_wr_q <= 1'b0;
            ph_rd_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (hready) begin
            ph_wr_q <= ph_take && hwrite;
            ph_rd_q <= ph_take && !hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end

    // Read data mux registered from the address phase; unmapped reads zero.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_q <= 32'h0;
        end else if (ph_take && !hwrite) begin
            case (haddr[7:0])
                `PIC_OFS_STATUS: hrdata_q <= {24'h0, req_sync};
                `PIC_OFS_CONFIG: hrdata_q <= {16'h0, mask_q, cfg_q};
                `PIC_OFS_INSERV: hrdata_q <= {16'h0, in_service_bits_q, pending_request_bits_q};
                `PIC_OFS_VECTOR: hrdata_q <= {22'h0, ack_st_q, data_q};
                `PIC_OFS_CMDDATA: hrdata_q <= {24'h0, cmd_rdata_q};
                default: hrdata_q <= 32'h0;
            endcase
        end
    end

    // Zero-wait OKAY response, held in flops so that every output leaves a register.
    reg hready_q;
    reg hresp_q;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp = hresp_q;
    assign int_req_o = int_q;
    assign data_o = data_q;
    assign data_oe_o = data_oe_q;
endmodule

// [test/pic_top_chk.sv]
// Checker for pic_top: bus response, interrupt line and vector handshake.
// Assumes ack pulses of at least three clocks high and low.
`timescale 1ns/1ps
`include "pic_consts.vh"
module pic_top_chk (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_n_i,
    // Bus signals.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    // Interrupt side.
    input wire int_req_o,
    input wire int_ack_i,
    input wire [7:0] data_o,
    input wire data_oe_o
);
    reg cmd_q; // A command port write is in its data phase.
    reg cfg_q; // The configuration word has been written.
    reg [4:0] base_q; // Shadow of the vector base.
    reg [7:0] mask_q; // Shadow of the mask.
    // Shadow the command port writes so vector and mask can be checked.
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_q <= 1'b0;
            cfg_q <= 1'b0;
            base_q <= 5'h00;
            mask_q <= 8'hff;
        end else begin
            cmd_q <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == `PIC_OFS_CMD);
            if (cmd_q && hwdata[`PIC_CMD_WR_BIT] && hwdata[`PIC_CMD_CS_BIT]) begin
                if (hwdata[`PIC_CMD_A0_BIT]) begin
                    mask_q <= hwdata[23:16];
                end else begin
                    cfg_q <= 1'b1;
                    base_q <= hwdata[23:19];
                end
            end
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_resp_okay: assert property (hresp == 1'b0) else $error("Response is not OKAY.");
    a_ready_high: assert property (hreadyout == 1'b1) else $error("Slave inserted a wait.");
    a_rst_quiet: assert property (disable iff (1'b0) !rst_n_i |-> !int_req_o && !data_oe_o)
        else $error("Outputs active in reset.");
    a_unconfig_quiet: assert property (!cfg_q |-> !int_req_o) else $error("Interrupt before config.");
    a_mask_blocks: assert property ($rose(int_req_o) |-> $past(mask_q) != 8'hff)
        else $error("Interrupt with all lines masked.");
    a_ack_takes: assert property ($rose(int_ack_i) && int_req_o |-> ##[1:5] !int_req_o)
        else $error("First ack did not drop the interrupt.");
    a_oe_on_ack: assert property ($rose(data_oe_o) |-> $past(int_ack_i, 2))
        else $error("Vector driven without a pulse.");
    a_oe_end_ack: assert property ($fell(data_oe_o) |-> !$past(int_ack_i, 2))
        else $error("Vector released inside the pulse.");
    a_first_dry: assert property ($fell(int_req_o) |-> !data_oe_o) else $error("Bus driven on first ack.");
    a_vec_base: assert property (data_oe_o |-> data_o[7:3] == base_q) else $error("Vector base wrong.");
    a_vec_hold: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
        else $error("Vector changed while driven.");
    a_oe_no_irq: assert property (data_oe_o |-> !int_req_o) else $error("Interrupt during vector.");
    c_vector: cover property ($rose(data_oe_o));
    c_irq: cover property ($rose(int_req_o));
    c_all_masked: cover property (cfg_q && mask_q == 8'hff);
endmodule
bind pic_top pic_top_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .int_req_o(int_req_o), .int_ack_i(int_ack_i), .data_o(data_o), .data_oe_o(data_oe_o));

// [test/pic_host.sv]
// Processor model: answers a raised interrupt with two acknowledge pulses.
// Assumes the controller's clock; pulse and gap lengths exceed its sync delay.
`timescale 1ns/1ps
module pic_host (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_n_i,
    // Interrupt handshake.
    input wire int_req_i,
    output logic int_ack_o
);
    initial int_ack_o = 1'b0;
    // Wait a random short time, then give the pulse pair and a recovery gap.
    always begin
        @(posedge clk_sys_i);
        if (rst_n_i === 1'b1 && int_req_i === 1'b1) begin
            repeat ($urandom % 4) @(posedge clk_sys_i);
            int_ack_o <= 1'b1;
            repeat (6) @(posedge clk_sys_i);
            int_ack_o <= 1'b0;
            repeat (6) @(posedge clk_sys_i);
            int_ack_o <= 1'b1;
            repeat (6) @(posedge clk_sys_i);
            int_ack_o <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
        end
    end
endmodule

// [test/tb_top.sv]
// Testbench of pic_top: bus master, request pins and a processor model.
// Assumes a zero-wait slave and a shortened tick period of 64 cycles.
`timescale 1ns/1ps
`include "pic_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b1; // Pulled low at time zero so the reset edge is seen.
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [7:0] req = 8'h00; // Request pins by line; slot 4 is unused.
    logic [7:0] exp_q[$]; // Expected vectors in order.
    logic [7:0] exp_v;
    logic [7:0] rs;
    logic oe_prev = 1'b0;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hready, hreadyout, hresp, int_req_o, int_ack_i, data_oe_o;
    wire [7:0] data_o;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    assign hready = hreadyout; // Single slave drives the bus ready.
    always #20 clk_sys_i = ~clk_sys_i;
    pic_top #(.TICK_CYC(32'h40)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rf_module_attention_req_i(req[0]),
        .remote_receive_ready_req_i(req[1]), .remote_transmit_ready_req_i(req[2]),
        .remote_receive_ready_aux_req_i(req[3]), .front_panel_attention_req_i(req[5]),
        .keyline_closed_req_i(req[6]), .keyline_open_req_i(req[7]), .int_req_o(int_req_o),
        .int_ack_i(int_ack_i), .data_o(data_o), .data_oe_o(data_oe_o));
    pic_host u_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .int_req_i(int_req_o), .int_ack_o(int_ack_i));
    // Print the verdict and stop.
    task complete_run;
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Cut a hang short.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            complete_run();
        end
    end
    // Compare each driven vector with the oldest expectation.
    always @(posedge clk_sys_i) begin
        oe_prev <= data_oe_o;
        if (data_oe_o === 1'b1 && oe_prev === 1'b0) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK(data_o, exp_v)
        end
    end
    // One single-word transfer; read data lands in rd.
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Command port write word for address bit a0.
    function logic [31:0] cmd(input logic a0, input logic [7:0] b);
        cmd = {8'h00, b, 5'h00, 1'b1, 1'b0, 1'b1, 7'h00, a0};
    endfunction
    // Wait, bounded, for the vector enable to reach a level.
    task wait_oe(input logic v);
        int n;
        n = 0;
        while (data_oe_o !== v && n < 500) begin
            @(posedge clk_sys_i);
            n++;
        end
        `CHK(data_oe_o, v)
    endtask
    // Pulse one request line and expect one serviced cycle.
    task fire(input int line);
        exp_q.push_back({5'h15, line[2:0]});
        @(posedge clk_sys_i);
        req[line] <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        req[line] <= 1'b0;
        wait_oe(1'b1);
        wait_oe(1'b0);
    endtask
    // Wait for n serviced cycles.
    task serve(input int n);
        repeat (n) begin
            wait_oe(1'b1);
            wait_oe(1'b0);
        end
    endtask
    // Main sequence.
    initial begin
        rd = $urandom(32'h3fb6);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        bus(1'b0, `PIC_OFS_CONFIG, 32'h0);
        `CHK(rd, 32'h0000ff00)
        req[2] <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        `CHK(int_req_o, 1'b0)
        req[2] <= 1'b0;
        bus(1'b0, 32'h40, 32'h0);
        `CHK(rd, 32'h0)
        exp_q.push_back(8'haa);
        bus(1'b1, `PIC_OFS_CMD, cmd(1'b0, 8'ha8));
        bus(1'b1, `PIC_OFS_CMD, cmd(1'b1, 8'h10));
        bus(1'b0, `PIC_OFS_CONFIG, 32'h0);
        `CHK(rd, 32'h000010a8)
        wait_oe(1'b1);
        wait_oe(1'b0);
        for (int i = 0; i < 6; i++) if (i != 4) fire(i);
        // Rotating priority: after line 2 the search starts at line 3, so 3 beats 1.
        bus(1'b1, `PIC_OFS_CMD, cmd(1'b0, 8'hac));
        fire(2);
        exp_q.push_back(8'hab);
        exp_q.push_back(8'ha9);
        req[3:0] <= 4'ha;
        repeat (4) @(posedge clk_sys_i);
        req[3:0] <= 4'h0;
        serve(2);
        // Back to fixed priority: lowest line first, whatever line was served last.
        bus(1'b1, `PIC_OFS_CMD, cmd(1'b0, 8'ha8));
        exp_q.push_back(8'hae);
        exp_q.push_back(8'haf);
        req[7:6] <= 2'b11;
        repeat (4) @(posedge clk_sys_i);
        req[6] <= 1'b0;
        serve(2);
        repeat (60) @(posedge clk_sys_i);
        `CHK(int_req_o, 1'b0)
        req[7] <= 1'b0;
        bus(1'b1, `PIC_OFS_CMD, cmd(1'b1, 8'h14));
        req[2] <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        `CHK(int_req_o, 1'b0)
        exp_q.push_back(8'hac);
        bus(1'b1, `PIC_OFS_CMD, cmd(1'b1, 8'hef));
        wait_oe(1'b1);
        bus(1'b1, `PIC_OFS_CMD, cmd(1'b1, 8'hff));
        wait_oe(1'b0);
        bus(1'b0, `PIC_OFS_VECTOR, 32'h0);
        `CHK(rd, 32'h000000ac)
        repeat (3) begin
            rs = $urandom & 8'hef;
            req <= rs;
            repeat (5) @(posedge clk_sys_i);
            bus(1'b0, `PIC_OFS_STATUS, 32'h0);
            `CHK(rd, {24'h0, rs})
        end
        req <= 8'h00;
        bus(1'b1, `PIC_OFS_CMD, 32'h00000301);
        bus(1'b0, `PIC_OFS_CMDDATA, 32'h0);
        `CHK(rd, 32'h000000ff)
        `CHK(exp_q.size(), 0)
        complete_run();
    end
endmodule
